// [common/flash_params.svh]
// Notes on behaviour
// - Each aligned 16-byte block has one check code; together they form a unit.
// - A unit stores 8 single-error-correcting check bits and one disable flag.
// - First program of a unit stores its code; later programs set its disable flag.
// - Sector erase clears every disable flag inside that sector.
// - Reads of enabled units correct any single-bit error before delivery.
// - Reads of disabled units return stored data without checking.
// - Correction covers all array space including OTP, never the registers.
// - Disable flags of OTP units, once set, are cleared only by reset; erasing the OTP region is refused.
// - Software can read, per unit, enable state and corrected-error flags.
// - Page is 256 or 512 bytes by a config bit, page aligned.
// - One program accepts anything from one byte up to a full page.
// - Program needs write enable latch set; programming only turns ones to zeros.
// - Opcode 02h takes 3 or 4 address bytes by config; 12h always 4.
// - Data beyond page end wraps to page byte zero, overwriting earlier bytes.
// - Short data programs only the sent bytes; rest of page untouched.
// - Write-in-progress status bit reads one while programming runs.
// - Program-error status bit sets only on a program whose start address is in the protected area.
// - In quad command mode bytes arrive four bits per clock.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
`define OP_WRITE_ENABLE      8'h06
`define OP_PAGE_PROGRAM      8'h02
`define OP_PAGE_PROGRAM_WIDE 8'h12
`define UNIT_BYTES           16
`define UNIT_BITS            128
`define CHECK_BITS           8
`define PAGE_LARGE           512
`define OFF_CFG2             8'h00
`define OFF_CFG3             8'h04
`define OFF_STATUS1          8'h08
`define OFF_PROTECT          8'h0c
`define OFF_ERASE            8'h10
`define OFF_ARRAY_ADDR       8'h14
`define OFF_ARRAY_DATA       8'h18
`define OFF_ECC_STATUS       8'h1c
`define CFG2_ADDR_LEN_BIT    7
`define CFG2_QUAD_BIT        6
`define CFG2_MASK            8'hc0
`define CFG3_PAGE_BIT        4
`define CFG3_MASK            8'h10
`define SR1_WIP_BIT          0
`define SR1_WEL_BIT          1
`define SR1_PERR_BIT         6
`endif

// [common/flash_pkg.sv]
`default_nettype none
`include "flash_params.svh"

package flash_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_PROG  = 2'b01,
		ST_ERASE = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		PH_CMD  = 2'b00,
		PH_ADDR = 2'b01,
		PH_DATA = 2'b10,
		PH_SKIP = 2'b11
	} phase_t;

	typedef struct packed {
		logic       sck_rise;
		logic       cs_fall;
		logic       cs_rise;
		logic       cs_n;
		logic [3:0] io;
	} link_sample_t;

	typedef logic [`UNIT_BITS-1:0]  unit_data_t;
	typedef logic [`CHECK_BITS-1:0] check_t;

	// Code position of data bit i, skipping power-of-two slots
	function automatic logic [7:0] code_pos(input int i);
		int p;
		p = i + 1;
		for (int j = 0; j < `CHECK_BITS; j++) begin
			if (p >= (1 << j)) begin
				p = p + 1;
			end
		end
		return 8'(p);
	endfunction

	// Hamming check bits over one unit
	function automatic check_t check_gen(input unit_data_t d);
		check_t     c;
		logic [7:0] pos;
		c = '0;
		for (int i = 0; i < `UNIT_BITS; i++) begin
			pos = code_pos(i);
			for (int j = 0; j < `CHECK_BITS; j++) begin
				if (pos[j]) begin
					c[j] = c[j] ^ d[i];
				end
			end
		end
		return c;
	endfunction

endpackage

`default_nettype wire

// [dv/flash_program_with_auto_ecc_test.sv]
`default_nettype none
`include "flash_params.svh"

module flash_page_program_with_auto_ecc_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_in, nrst_in, hwrite, hrdy, hresp;
	logic        sck, cs_n;
	logic [3:0]  io;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, r;
	int          errors, n_compared, cycles;

	// ---------------------------------------------
	// Clock and timeout
	// ---------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			test_done();
		end
	end

	flash_program dut_u (
		.clk_in(clk_in), .nrst_in(nrst_in), .sck_in(sck),
		.cs_n_in(cs_n), .io_in(io), .hsel_in(1'b1),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
		.hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp)
	);
	spi_host_model host_u (.sck_out(sck), .cs_n_out(cs_n), .io_out(io));

	// ---------------------------------------------
	// Bus, compare and program helpers
	// ---------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_in); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hrdy !== 1'b1);
		r = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(r, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wait_idle();
		repeat (8) @(posedge clk_in);
		for (int i = 0; i < 128; i++) begin
			ahb(1'b0, `OFF_STATUS1, 32'h0);
			if (r[0] === 1'b0) break;
		end
		chk({31'h0, r[0]}, 32'h0);
	endtask

	// write enable frame before the program only when write_enable_latch is set
	task automatic prog(input logic write_enable_latch, input logic [23:0] a, input logic [7:0] d[$]);
		if (write_enable_latch) host_u.frame('{8'h06});
		host_u.frame({8'h02, a[23:16], a[15:8], a[7:0], d});
		wait_idle();
	endtask

	task automatic word_at(input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b1, `OFF_ARRAY_ADDR, a);
		rd_chk(`OFF_ARRAY_DATA, exp);
	endtask

	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task automatic t_refused();
		rd_chk(8'h20, 32'h0);
		prog(1'b0, 24'h000200, '{8'h00});
		rd_chk(`OFF_STATUS1, 32'h0);
		word_at(32'h200, 32'hffffffff);
		$display("refused program done");
	endtask

	task automatic t_units();
		logic [7:0] d[$];
		for (int i = 0; i < 16; i++) d.push_back(8'h10 + 8'(i));
		prog(1'b1, 24'h000000, d);
		rd_chk(`OFF_STATUS1, 32'h0);
		word_at(32'h4, 32'h17161514);
		rd_chk(`OFF_ECC_STATUS, 32'h0);
		prog(1'b1, 24'h000005, '{8'hf0});
		word_at(32'h4, 32'h17161014);
		rd_chk(`OFF_ECC_STATUS, 32'h1);
		$display("unit program done");
	endtask

	task automatic t_wrap_quad();
		ahb(1'b1, `OFF_CFG2, 32'h40);
		host_u.quad = 1'b1;
		prog(1'b1, 24'h0001fe, '{8'ha1, 8'ha2, 8'ha3});
		host_u.quad = 1'b0;
		ahb(1'b1, `OFF_CFG2, 32'h0);
		word_at(32'h100, 32'hffffffa3);
		word_at(32'h1fc, 32'ha2a1ffff);
		$display("wrap quad done");
	endtask

	task automatic t_erase();
		host_u.frame('{8'h06});
		ahb(1'b1, `OFF_ERASE, 32'h0);
		rd_chk(`OFF_STATUS1, 32'h3);
		wait_idle();
		word_at(32'h4, 32'hffffffff);
		rd_chk(`OFF_ECC_STATUS, 32'h0);
		$display("erase done");
	endtask

	task automatic t_protect();
		ahb(1'b1, `OFF_PROTECT, 32'h100);
		prog(1'b1, 24'h000000, '{8'h00});
		rd_chk(`OFF_STATUS1, 32'h40);
		word_at(32'h0, 32'hffffffff);
		ahb(1'b1, `OFF_STATUS1, 32'h40);
		rd_chk(`OFF_STATUS1, 32'h0);
		$display("protect done");
	endtask

	// Wide opcode, 512-byte page wrap, OTP sector erase refused
	task automatic t_wide_otp();
		ahb(1'b1, `OFF_CFG3, 32'h10);
		host_u.frame('{8'h06});
		host_u.frame('{8'h12, 8'h00, 8'h00, 8'h03, 8'hfe,
		               8'hb1, 8'hb2, 8'hb3});
		wait_idle();
		word_at(32'h200, 32'hffffffb3);
		word_at(32'h3fc, 32'hb2b1ffff);
		host_u.frame('{8'h06});
		ahb(1'b1, `OFF_ERASE, 32'h1);
		rd_chk(`OFF_STATUS1, 32'h2);
		ahb(1'b1, `OFF_CFG3, 32'h0);
		$display("wide address done");
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		nrst_in = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		t_refused();
		t_units();
		t_wrap_quad();
		t_erase();
		t_protect();
		t_wide_otp();
		test_done();
	end
endmodule

`default_nettype wire

// [dv/spi_host_model.sv]
`default_nettype none

module spi_host_model (
	output logic       sck_out,
	output logic       cs_n_out,
	output logic [3:0] io_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic quad;

	// Clock stands still low outside frames
	initial begin
		quad = 1'b0;
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		io_out = 4'h0;
	end

	task automatic put(input logic [7:0] b);
		for (int i = 0; i < (quad ? 2 : 8); i++) begin
			if (quad) begin
				io_out = (i == 0) ? b[7:4] : b[3:0];
			end else begin
				io_out = {3'h0, b[7 - i]};
			end
			#40 sck_out = 1'b1;
			#40 sck_out = 1'b0;
		end
	endtask

	// whole bytes, cs rises on boundary
	task automatic frame(input logic [7:0] q[$]);
		cs_n_out = 1'b0;
		#40;
		foreach (q[i]) begin
			put(q[i]);
		end
		#40 cs_n_out = 1'b1;
		io_out = ~io_out;
		#200;
	endtask
endmodule

`default_nettype wire

// [logic/ecc_codec.sv]
`default_nettype none
`include "flash_params.svh"

module ecc_codec (
	input  wire flash_pkg::unit_data_t data_in,
	input  wire flash_pkg::check_t     check_in,
	input  wire logic                  enable_in,
	output flash_pkg::unit_data_t      data_out,
	output logic                       data_err_out,
	output logic                       check_err_out
);
	import flash_pkg::*;

	logic [7:0] syn;
	logic       single_chk;

	// Syndrome; zero when checking is off
	assign syn = enable_in ? (check_in ^ check_gen(data_in)) : 8'h00;
	assign single_chk = (syn != 8'h00) && ((syn & (syn - 8'h01)) == 8'h00);
	assign data_err_out  = (syn != 8'h00) && !single_chk;
	assign check_err_out = single_chk;

	// Flip the one data bit the syndrome points at
	for (genvar i = 0; i < `UNIT_BITS; i++) begin : g_fix
		assign data_out[i] = data_in[i] ^ (syn == code_pos(i));
	end

endmodule

`default_nettype wire

// [logic/flash_program.sv]
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`default_nettype none
`include "flash_params.svh"

module flash_program #(
	parameter int ARRAY_BYTES  = 8192,
	parameter int SECTOR_BYTES = 4096,
	parameter int OTP_BYTES    = 1024
) (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        sck_in,
	input  wire logic        cs_n_in,
	input  wire logic [3:0]  io_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out
);
	import flash_pkg::*;

	localparam int UNITS      = ARRAY_BYTES / `UNIT_BYTES;
	localparam int UW         = $clog2(UNITS);
	localparam int AW         = $clog2(ARRAY_BYTES);
	localparam int SEC_UNITS  = SECTOR_BYTES / `UNIT_BYTES;
	localparam int SW         = $clog2(SEC_UNITS);
	localparam int SECTORS    = ARRAY_BYTES / SECTOR_BYTES;
	localparam int SECW       = $clog2(SECTORS);
	localparam int OTP_SECTOR = (ARRAY_BYTES - OTP_BYTES) / SECTOR_BYTES;
	localparam int OTP_UNIT   = (ARRAY_BYTES - OTP_BYTES) / `UNIT_BYTES;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if ((ARRAY_BYTES & (ARRAY_BYTES - 1)) != 0 ||
	    (SECTOR_BYTES & (SECTOR_BYTES - 1)) != 0 ||
	    SECTOR_BYTES < `PAGE_LARGE || SECTORS < 2 ||
	    OTP_BYTES % `UNIT_BYTES != 0 || OTP_BYTES >= ARRAY_BYTES) begin : g_bad
		$error("flash_program: unsupported array geometry");
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	unit_data_t       mem_reg [UNITS];
	check_t           ecc_reg [UNITS];
	logic [UNITS-1:0] dis_reg;
	logic [UNITS-1:0] used_reg;
	logic [7:0]       pbuf_reg [`PAGE_LARGE];
	logic [511:0]     mask_reg;

	// Link and command state
	link_sample_t     smp;
	phase_t           phase_reg;
	logic [7:0]       cmd_reg;
	logic [7:0]       shift_reg;
	logic [2:0]       bcnt_reg;
	logic [1:0]       alen_reg;
	logic [31:0]      addr_reg;
	logic [8:0]       ptr_reg;
	logic             got_reg;

	// Control and status
	logic [7:0]       cfg2_reg;
	logic [7:0]       cfg3_reg;
	logic             wel_reg;
	logic             perr_reg;
	logic [AW:0]      prot_reg;
	logic [AW-1:0]    arr_addr_reg;
	seq_state_t       st_reg;
	logic [SW-1:0]    unit_cnt_reg;
	logic [UW-1:0]    base_reg;
	logic             big_reg;

	// Bus state
	logic             wr_pend_reg;
	logic [7:0]       wr_off_reg;
	logic [31:0]      hrdata_reg;
	logic             hreadyout_reg;
	logic             hresp_reg;

	// ----------------------------------------
	// Link sampling
	// ----------------------------------------
	link_sync u_link (
		.clk_in     (clk_in),
		.nrst_in    (nrst_in),
		.sck_in     (sck_in),
		.cs_n_in    (cs_n_in),
		.io_in      (io_in),
		.sample_out (smp)
	);

	// ----------------------------------------
	// Byte assembly and decode
	// ----------------------------------------
	logic             quad;
	logic             wide;
	logic             page512;
	logic             idle;
	logic             step;
	logic [2:0]       bcnt_next;
	logic [7:0]       shift_next;
	logic             byte_done;
	logic             is_pp;
	logic [31:0]      addr_next;
	logic [8:0]       pmask;
	logic             store;
	logic             cs_end;
	logic             write_enable_cmd_ok;
	logic             pp_ok;
	logic [AW-1:0]    start_addr;
	logic             prot_hit;
	logic [UW-1:0]    pg_unit;

	// Config decode
	assign quad    = cfg2_reg[`CFG2_QUAD_BIT];
	assign wide    = cfg2_reg[`CFG2_ADDR_LEN_BIT];
	assign page512 = cfg3_reg[`CFG3_PAGE_BIT];
	assign idle    = st_reg == ST_IDLE;

	assign step       = smp.sck_rise && !smp.cs_n && idle;
	assign bcnt_next  = bcnt_reg + (quad ? 3'h4 : 3'h1);
	assign shift_next = quad ? {shift_reg[3:0], smp.io}
	                         : {shift_reg[6:0], smp.io[0]};
	assign byte_done  = step && bcnt_next == 3'h0;
	assign is_pp      = shift_next == `OP_PAGE_PROGRAM ||
	                    shift_next == `OP_PAGE_PROGRAM_WIDE;
	assign addr_next  = {addr_reg[23:0], shift_next};

	assign pmask = page512 ? 9'h1ff : 9'h0ff;
	assign store = byte_done && phase_reg == PH_DATA;

	assign cs_end  = smp.cs_rise && idle;
	assign write_enable_cmd_ok = cs_end && phase_reg == PH_SKIP &&
	                 cmd_reg == `OP_WRITE_ENABLE && bcnt_reg == 3'h0;
	assign pp_ok   = cs_end && phase_reg == PH_DATA && got_reg &&
	                 bcnt_reg == 3'h0 && wel_reg;

	assign start_addr = addr_reg[AW-1:0];
	assign prot_hit   = {1'b0, start_addr} < prot_reg;
	assign pg_unit = {start_addr[AW-1:9], start_addr[8] & ~page512, 4'h0};

	// Frame and byte capture
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			phase_reg <= PH_SKIP;
			cmd_reg   <= 8'h00;
			shift_reg <= 8'h00;
			bcnt_reg  <= 3'h0;
			alen_reg  <= 2'h0;
			addr_reg  <= 32'h0;
			ptr_reg   <= 9'h000;
			got_reg   <= 1'b0;
			mask_reg  <= '0;
		end else if (smp.cs_fall) begin
			phase_reg <= idle ? PH_CMD : PH_SKIP;
			cmd_reg   <= 8'h00;
			bcnt_reg  <= 3'h0;
			got_reg   <= 1'b0;
		end else if (step) begin
			bcnt_reg  <= bcnt_next;
			shift_reg <= shift_next;
			if (byte_done) begin
				unique case (phase_reg)
					PH_CMD: begin
						cmd_reg   <= shift_next;
						phase_reg <= is_pp ? PH_ADDR : PH_SKIP;
						alen_reg  <= (wide || shift_next ==
						             `OP_PAGE_PROGRAM_WIDE) ? 2'h3 : 2'h2;
						if (is_pp) begin
							mask_reg <= '0;
						end
					end
					PH_ADDR: begin
						addr_reg <= addr_next;
						alen_reg <= alen_reg - 2'h1;
						ptr_reg  <= addr_next[8:0] & pmask;
						if (alen_reg == 2'h0) begin
							phase_reg <= PH_DATA;
						end
					end
					PH_DATA: begin
						got_reg <= 1'b1;
						ptr_reg <= (ptr_reg + 9'h001) & pmask;
						mask_reg[ptr_reg] <= 1'b1;
					end
					PH_SKIP: begin
					end
				endcase
			end
		end
	end

	// Page buffer bytes
	always_ff @(posedge clk_in) begin
		if (store) begin
			pbuf_reg[ptr_reg] <= shift_next;
		end
	end

	// ----------------------------------------
	// Program and erase sequencing
	// ----------------------------------------
	logic [UW-1:0]    cur_unit;
	logic [15:0]      umask;
	unit_data_t       pdata;
	unit_data_t       emask;
	unit_data_t       old_data;
	unit_data_t       new_data;
	logic             prog_write;
	logic             prog_last;
	logic             erase_last;
	logic             seq_done;
	logic             erase_go;
	logic [SECW-1:0]  erase_sec;
	logic             perr_clr;

	assign cur_unit = base_reg + UW'(unit_cnt_reg);
	assign umask    = mask_reg[{unit_cnt_reg[4:0], 4'h0} +: 16];

	// Gather one buffered unit and its byte mask
	for (genvar b = 0; b < `UNIT_BYTES; b++) begin : g_unit
		assign pdata[b*8 +: 8] = pbuf_reg[{unit_cnt_reg[4:0], 4'(b)}];
		assign emask[b*8 +: 8] = {8{umask[b]}};
	end

	assign old_data   = used_reg[cur_unit] ? mem_reg[cur_unit] : '1;
	assign new_data   = old_data & (pdata | ~emask);
	assign prog_write = st_reg == ST_PROG && umask != 16'h0000;
	assign prog_last  = unit_cnt_reg == SW'({big_reg, 4'hf});
	assign erase_last = &unit_cnt_reg;
	assign seq_done   = (st_reg == ST_PROG && prog_last) ||
	                    (st_reg == ST_ERASE && erase_last);

	assign erase_sec = hwdata_in[SECW-1:0];
	assign erase_go  = wr_pend_reg && wr_off_reg == `OFF_ERASE && idle &&
	                   wel_reg && 32'(erase_sec) < OTP_SECTOR;
	assign perr_clr  = wr_pend_reg && wr_off_reg == `OFF_STATUS1 &&
	                   hwdata_in[`SR1_PERR_BIT];

	// Array data and check code writes
	always_ff @(posedge clk_in) begin
		if (prog_write) begin
			mem_reg[cur_unit] <= new_data;
			if (!used_reg[cur_unit]) begin
				ecc_reg[cur_unit] <= check_gen(new_data);
			end
		end
	end

	// Per-unit flags
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			used_reg <= '0;
			dis_reg  <= '0;
		end else if (prog_write) begin
			used_reg[cur_unit] <= 1'b1;
			if (used_reg[cur_unit]) begin
				dis_reg[cur_unit] <= 1'b1;
			end
		end else if (st_reg == ST_ERASE) begin
			used_reg[cur_unit] <= 1'b0;
			dis_reg[cur_unit]  <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_reg       <= ST_IDLE;
			unit_cnt_reg <= '0;
			base_reg     <= '0;
			big_reg      <= 1'b0;
		end else begin
			unique case (st_reg)
				ST_IDLE: begin
					unit_cnt_reg <= '0;
					if (pp_ok && !prot_hit) begin
						st_reg   <= ST_PROG;
						base_reg <= pg_unit;
						big_reg  <= page512;
					end else if (erase_go) begin
						st_reg   <= ST_ERASE;
						base_reg <= {erase_sec, SW'(0)};
					end
				end
				ST_PROG, ST_ERASE: begin
					unit_cnt_reg <= unit_cnt_reg + SW'(1);
					if (seq_done) begin
						st_reg <= ST_IDLE;
					end
				end
				default: begin
					st_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Write enable latch and program error
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wel_reg  <= 1'b0;
			perr_reg <= 1'b0;
		end else begin
			if (write_enable_cmd_ok) begin
				wel_reg <= 1'b1;
			end else if ((pp_ok && prot_hit) || seq_done) begin
				wel_reg <= 1'b0;
			end
			perr_reg <= (pp_ok && prot_hit) || (perr_reg && !perr_clr);
		end
	end

	// ----------------------------------------
	// Corrected read path
	// ----------------------------------------
	logic [UW-1:0]    rd_unit;
	unit_data_t       rd_fixed;
	logic             rd_data_err;
	logic             rd_chk_err;
	logic [31:0]      rd_word;

	assign rd_unit = arr_addr_reg[AW-1:4];

	ecc_codec u_codec (
		.data_in       (used_reg[rd_unit] ? mem_reg[rd_unit] : '1),
		.check_in      (ecc_reg[rd_unit]),
		.enable_in     (used_reg[rd_unit] && !dis_reg[rd_unit]),
		.data_out      (rd_fixed),
		.data_err_out  (rd_data_err),
		.check_err_out (rd_chk_err)
	);

	assign rd_word = rd_fixed[{arr_addr_reg[3:2], 5'h00} +: 32];

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	logic             ahb_take;
	logic [7:0]       rd_off;
	logic [7:0]       sr1;
	logic [31:0]      rd_mux;

	assign ahb_take = hsel_in && htrans_in[1] && hready_in;
	assign rd_off   = haddr_in[7:0];
	assign sr1 = {1'b0, perr_reg, 4'h0, wel_reg, !idle};

	assign rd_mux =
		rd_off == `OFF_CFG2       ? {24'h0, cfg2_reg} :
		rd_off == `OFF_CFG3       ? {24'h0, cfg3_reg} :
		rd_off == `OFF_STATUS1    ? {24'h0, sr1} :
		rd_off == `OFF_PROTECT    ? 32'(prot_reg) :
		rd_off == `OFF_ARRAY_ADDR ? 32'(arr_addr_reg) :
		rd_off == `OFF_ARRAY_DATA ? rd_word :
		rd_off == `OFF_ECC_STATUS ?
			{29'h0, rd_chk_err, rd_data_err, dis_reg[rd_unit]} :
		32'h0;

	// Phase tracking; one wait state after each write
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_pend_reg   <= 1'b0;
			wr_off_reg    <= 8'h00;
			hrdata_reg    <= 32'h0;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end else begin
			wr_pend_reg   <= ahb_take && hwrite_in;
			hreadyout_reg <= !(ahb_take && hwrite_in);
			if (ahb_take) begin
				wr_off_reg <= rd_off;
			end
			if (ahb_take && !hwrite_in) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	// Register writes in data phase
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg2_reg     <= 8'h00;
			cfg3_reg     <= 8'h00;
			prot_reg     <= '0;
			arr_addr_reg <= '0;
		end else if (wr_pend_reg) begin
			if (wr_off_reg == `OFF_CFG2) begin
				cfg2_reg <= hwdata_in[7:0] & `CFG2_MASK;
			end
			if (wr_off_reg == `OFF_CFG3) begin
				cfg3_reg <= hwdata_in[7:0] & `CFG3_MASK;
			end
			if (wr_off_reg == `OFF_PROTECT) begin
				prot_reg <= hwdata_in[AW:0];
			end
			if (wr_off_reg == `OFF_ARRAY_ADDR) begin
				arr_addr_reg <= hwdata_in[AW-1:0];
			end
		end
	end

	assign hrdata_out    = hrdata_reg;
	assign hreadyout_out = hreadyout_reg;
	assign hresp_out     = hresp_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	prog_start_a: assert property (
		pp_ok && !prot_hit |=> st_reg == ST_PROG && sr1[0])
		else $error("program did not start busy");
	need_wel_a: assert property (
		$rose(st_reg == ST_PROG) |-> $past(wel_reg))
		else $error("program began without latch");
	only_clears_a: assert property (
		prog_write && used_reg[cur_unit] |=>
		(mem_reg[$past(cur_unit)] & ~$past(mem_reg[cur_unit])) == '0)
		else $error("program raised a bit");
	end_clears_wel_a: assert property (
		st_reg == ST_PROG && prog_last |=> !wel_reg && idle)
		else $error("latch not cleared at end");
	second_prog_off_a: assert property (
		prog_write && used_reg[cur_unit] |=> dis_reg[$past(cur_unit)])
		else $error("reprogram left correction on");
	first_prog_code_a: assert property (
		prog_write && !used_reg[cur_unit] |=>
		ecc_reg[$past(cur_unit)] == check_gen($past(new_data)))
		else $error("check code not stored");
	erase_clears_a: assert property (
		st_reg == ST_ERASE |=> !dis_reg[$past(cur_unit)])
		else $error("erase kept disable flag");
	otp_kept_a: assert property (
		st_reg == ST_ERASE |-> 32'(cur_unit) < OTP_UNIT)
		else $error("erase reached OTP");
	no_wel_ignored_a: assert property (
		cs_end && phase_reg == PH_DATA && !wel_reg && !perr_clr |=>
		idle && perr_reg == $past(perr_reg))
		else $error("program without latch acted");
	page_wrap_a: assert property (
		store && ptr_reg == pmask |=> ptr_reg == 9'h000)
		else $error("buffer did not wrap");
	protect_err_a: assert property (
		pp_ok && prot_hit |=> perr_reg && idle)
		else $error("protected program not flagged");

endmodule

`default_nettype wire

// [logic/link_sync.sv]
`default_nettype none

module link_sync (
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	input  wire logic              sck_in,
	input  wire logic              cs_n_in,
	input  wire logic [3:0]        io_in,
	output flash_pkg::link_sample_t sample_out
);
	import flash_pkg::*;

	logic [5:0] meta_reg;
	logic [5:0] sync_reg;
	logic [1:0] prev_reg;

	// Two-stage sync of {cs_n, sck, io}, then edge history
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_reg <= 6'h20;
			sync_reg <= 6'h20;
			prev_reg <= 2'h2;
		end else begin
			meta_reg <= {cs_n_in, sck_in, io_in};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg[5:4];
		end
	end

	// Edge pulses from synced levels only
	assign sample_out.sck_rise = sync_reg[4] & ~prev_reg[0];
	assign sample_out.cs_rise  = sync_reg[5] & ~prev_reg[1];
	assign sample_out.cs_fall  = ~sync_reg[5] & prev_reg[1];
	assign sample_out.cs_n     = sync_reg[5];
	assign sample_out.io       = sync_reg[3:0];

endmodule

`default_nettype wire
